// ==== pkg/address_space_decoder_params.svh ====
// constants for the address space decoder
`ifndef ADDRESS_SPACE_DECODER_PARAMS_SVH
`define ADDRESS_SPACE_DECODER_PARAMS_SVH
`define RF_ADDR_W        12
`define RF_SIZE_BYTES    13'h1000
`define CTRL_BASE        12'hf00
`define CTRL_LAST        12'hfff
`define RAM_BASE         12'h000
`define RAM_SIZE_MIN     13'h0800
`define RAM_SIZE_MAX     13'h1000
`define PM_ADDR_W        16
`define FLASH_SIZE_MIN   17'h04000
`define FLASH_SIZE_MAX   17'h10000
`define PM_BLANK         8'hff
`define PM_OPTION_BASE   16'h0000
`define PM_RESET_VEC     16'h0002
`define PM_WATCHDOG_VEC  16'h0004
`define PM_TRAP_VEC      16'h0006
`define PM_IRQ_VEC_BASE  16'h0008
`define PM_IRQ_VEC_LAST  16'h0037
`define PM_CODE_BASE     16'h0038
`define PM_REGION_RESET  3'h0
`define UNDEF_READ       8'h00
`endif

// ==== pkg/address_space_decoder_pkg.sv ====
// types for the address space decoder
package address_space_decoder_pkg;
   typedef enum logic [1:0] {
      RF_RAM      = 2'h0,
      RF_CTRL     = 2'h1,
      RF_HOLE     = 2'h3
   } rf_target_t;
   typedef enum logic [2:0] {
      PM_OPTION   = 3'h0,
      PM_RESET    = 3'h1,
      PM_WATCHDOG = 3'h3,
      PM_TRAP     = 3'h2,
      PM_IRQ      = 3'h6,
      PM_CODE     = 3'h7,
      PM_ABSENT   = 3'h5
   } pm_region_t;
endpackage

// ==== rtl/address_space_decoder.sv ====
// register file, program memory and data memory address decoder
// How it works
// - three spaces decoded: register file, program memory, data memory
// - register file spans 4096 bytes, split into ram and control parts
// - top 256 bytes f00-fff go to core, peripheral and port registers
// - reserved control reads undefined; software should not write them
// - ram starts at 000, implemented size 2kb to 4kb per variant
// - gap above ram below control reads undefined, writes change nothing
// - source operands are read, destination operands are written
// - program space 64kb, implemented flash 16kb to 64kb per variant
// - program reads beyond flash give ff, writes there are dropped
// - option bits, reset, watchdog, trap and interrupt vectors at bottom
// - code and data from 0038 to the top of implemented flash
// - data memory space unused; nothing answers there
`timescale 1ns/1ps
`default_nettype none
`include "address_space_decoder_params.svh"
module address_space_decoder #(
   parameter logic [12:0] RAM_SIZE   = 13'h1000,
   parameter logic [16:0] FLASH_SIZE = 17'h10000
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        rf_rd,
   input  wire logic        rf_wr,
   input  wire logic [11:0] rf_addr,
   input  wire logic [7:0]  rf_wdata,
   output var  logic [7:0]  rf_rdata,
   output var  logic        rf_rvalid,
   output var  logic        ram_rd,
   output var  logic        ram_wr,
   output var  logic [11:0] ram_addr,
   output var  logic [7:0]  ram_wdata,
   input  wire logic [7:0]  ram_rdata,
   output var  logic        periph_rd,
   output var  logic        periph_wr,
   output var  logic [7:0]  periph_addr,
   output var  logic [7:0]  periph_wdata,
   input  wire logic [7:0]  periph_rdata,
   input  wire logic        periph_hit,
   input  wire logic        pm_rd,
   input  wire logic        pm_wr,
   input  wire logic [15:0] pm_addr,
   input  wire logic [7:0]  pm_wdata,
   output var  logic [7:0]  pm_rdata,
   output var  logic        pm_rvalid,
   output var  logic [2:0]  pm_region,
   output var  logic        flash_rd,
   output var  logic        flash_wr,
   output var  logic [15:0] flash_addr,
   output var  logic [7:0]  flash_wdata,
   input  wire logic [7:0]  flash_rdata,
   input  wire logic        dm_rd,
   input  wire logic        dm_wr,
   input  wire logic [15:0] dm_addr,
   output var  logic        dm_ack
);
   address_space_decoder_pkg::rf_target_t rf_target;
   address_space_decoder_pkg::rf_target_t rf_target_q;
   address_space_decoder_pkg::rf_target_t next_rf_target_q;
   address_space_decoder_pkg::pm_region_t pm_reg;
   logic        ram_hit;
   logic        flash_hit;
   logic        pm_absent_q;
   logic        next_pm_absent_q;
   logic        next_rf_rvalid;
   logic        next_pm_rvalid;
   logic        periph_hit_q;
   logic        next_periph_hit_q;
   logic [7:0]  next_rf_rdata;
   logic [7:0]  next_pm_rdata;
   logic [2:0]  next_pm_region;
   logic        ram_sel;
   logic        periph_sel;
   logic [12:0] ram_size_eff;
   logic [16:0] flash_size_eff;

   // ram size is a variant strap, clamped into the legal 2kb..4kb range
   always_comb begin
      if (RAM_SIZE < `RAM_SIZE_MIN) begin
         ram_size_eff = `RAM_SIZE_MIN;
      end else if (RAM_SIZE > `RAM_SIZE_MAX) begin
         ram_size_eff = `RAM_SIZE_MAX;
      end else begin
         ram_size_eff = RAM_SIZE;
      end
   end

   // flash size clamped the same way, 16kb..64kb
   always_comb begin
      if (FLASH_SIZE < `FLASH_SIZE_MIN) begin
         flash_size_eff = `FLASH_SIZE_MIN;
      end else if (FLASH_SIZE > `FLASH_SIZE_MAX) begin
         flash_size_eff = `FLASH_SIZE_MAX;
      end else begin
         flash_size_eff = FLASH_SIZE;
      end
   end

   // register file decode; control region wins over a full 4kb ram
   always_comb begin
      ram_hit = ({1'b0, rf_addr} < ram_size_eff);
      if (rf_addr >= `CTRL_BASE) begin
         rf_target = address_space_decoder_pkg::RF_CTRL;
      end else if (ram_hit) begin
         rf_target = address_space_decoder_pkg::RF_RAM;
      end else begin
         rf_target = address_space_decoder_pkg::RF_HOLE;
      end
   end

   // source reads and destination writes steered to one target only
   always_comb begin
      ram_sel      = (rf_target == address_space_decoder_pkg::RF_RAM);
      periph_sel   = (rf_target == address_space_decoder_pkg::RF_CTRL);
      ram_rd       = rf_rd && ram_sel;
      ram_wr       = rf_wr && ram_sel;
      ram_addr     = rf_addr;
      ram_wdata    = rf_wdata;
      // reserved control writes are still forwarded; the peripheral decides
      periph_rd    = rf_rd && periph_sel;
      periph_wr    = rf_wr && periph_sel;
      periph_addr  = rf_addr[7:0];
      periph_wdata = rf_wdata;
   end

   // program memory decode of vector layout and implemented flash
   always_comb begin
      flash_hit = ({1'b0, pm_addr} < flash_size_eff);
      if (!flash_hit) begin
         pm_reg = address_space_decoder_pkg::PM_ABSENT;
      end else if (pm_addr < `PM_RESET_VEC) begin
         pm_reg = address_space_decoder_pkg::PM_OPTION;
      end else if (pm_addr < `PM_WATCHDOG_VEC) begin
         pm_reg = address_space_decoder_pkg::PM_RESET;
      end else if (pm_addr < `PM_TRAP_VEC) begin
         pm_reg = address_space_decoder_pkg::PM_WATCHDOG;
      end else if (pm_addr < `PM_IRQ_VEC_BASE) begin
         pm_reg = address_space_decoder_pkg::PM_TRAP;
      end else if (pm_addr <= `PM_IRQ_VEC_LAST) begin
         pm_reg = address_space_decoder_pkg::PM_IRQ;
      end else begin
         pm_reg = address_space_decoder_pkg::PM_CODE;
      end
      flash_rd    = pm_rd && flash_hit;
      flash_wr    = pm_wr && flash_hit;
      flash_addr  = pm_addr;
      flash_wdata = pm_wdata;
   end

   // nothing on chip answers the data memory space
   assign dm_ack = 1'b0;

   // register file read answer, one cycle after the strobe like the ram array
   always_comb begin
      next_rf_rvalid = rf_rd;
      if (rf_rd) begin
         next_rf_target_q  = rf_target;
         next_periph_hit_q = periph_hit;
      end else begin
         next_rf_target_q  = rf_target_q;
         next_periph_hit_q = periph_hit_q;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rf_rvalid    <= 1'b0;
         rf_target_q  <= address_space_decoder_pkg::RF_RAM;
         periph_hit_q <= 1'b0;
      end else begin
         rf_rvalid    <= next_rf_rvalid;
         rf_target_q  <= next_rf_target_q;
         periph_hit_q <= next_periph_hit_q;
      end
   end

   // program memory read answer one cycle after the strobe; region code registered from pm_addr every cycle, strobe or not
   always_comb begin
      next_pm_rvalid = pm_rd;
      next_pm_region = pm_reg;
      if (pm_rd) begin
         next_pm_absent_q = !flash_hit;
      end else begin
         next_pm_absent_q = pm_absent_q;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pm_rvalid   <= 1'b0;
         pm_absent_q <= 1'b0;
         pm_region   <= `PM_REGION_RESET;
      end else begin
         pm_rvalid   <= next_pm_rvalid;
         pm_absent_q <= next_pm_absent_q;
         pm_region   <= next_pm_region;
      end
   end

   // undefined reads give a fixed value so simulation never sees x;
   // the mux stays combinational since array data only lands after the strobe edge
   always_comb begin
      case (rf_target_q)
         address_space_decoder_pkg::RF_RAM: begin
            next_rf_rdata = ram_rdata;
         end
         address_space_decoder_pkg::RF_CTRL: begin
            if (periph_hit_q) begin
               next_rf_rdata = periph_rdata;
            end else begin
               next_rf_rdata = `UNDEF_READ;
            end
         end
         default: begin
            next_rf_rdata = `UNDEF_READ;
         end
      endcase
   end

   // absent flash reads as erased bytes
   always_comb begin
      if (pm_absent_q) begin
         next_pm_rdata = `PM_BLANK;
      end else begin
         next_pm_rdata = flash_rdata;
      end
   end

   assign rf_rdata = next_rf_rdata;
   assign pm_rdata = next_pm_rdata;
endmodule // address_space_decoder
`default_nettype wire

// ==== verif/asd_far_side.sv ====
// memory and peripheral model on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module asd_far_side (
   input  wire logic        clk, reset, ram_rd, periph_rd, flash_rd,
   input  wire logic [11:0] ram_addr,
   input  wire logic [7:0]  periph_addr,
   input  wire logic [15:0] flash_addr,
   output var  logic [7:0]  ram_rdata, periph_rdata, flash_rdata,
   output var  logic        periph_hit
);
   // unselected data flips every cycle so a stale value never passes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ram_rdata <= 8'h00;
         periph_rdata <= 8'h00;
         flash_rdata <= 8'h00;
      end else begin
         ram_rdata <= ram_rd ? ram_addr[7:0] ^ 8'h5a : ~ram_rdata;
         periph_rdata <= periph_rd ? periph_addr ^ 8'ha5 : ~periph_rdata;
         flash_rdata <= flash_rd ? flash_addr[7:0] ^ flash_addr[15:8] : ~flash_rdata;
      end
   end
   assign periph_hit = periph_addr != 8'hff;
endmodule // asd_far_side
`default_nettype wire

// ==== verif/asd_checker_sva.sv ====
// assertions for the address space decoder
`timescale 1ns/1ps
`default_nettype none
`include "address_space_decoder_params.svh"
module asd_checker #(
   parameter logic [12:0] RAM_SIZE = 13'h1000,
   parameter logic [16:0] FLASH_SIZE = 17'h10000
) (
   input  wire logic        clk, reset, rf_rd, rf_wr, rf_rvalid, ram_rd, ram_wr, periph_rd,
   input  wire logic        periph_wr, periph_hit, pm_rd, pm_wr, pm_rvalid, flash_rd,
   input  wire logic        flash_wr, dm_ack,
   input  wire logic [11:0] rf_addr,
   input  wire logic [15:0] pm_addr,
   input  wire logic [7:0]  rf_rdata, pm_rdata,
   input  wire logic [2:0]  pm_region
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic gap, ctl, acc, ram_ok, ctl_ok, quiet, pm_out;
   assign gap = {1'b0, rf_addr} >= RAM_SIZE && rf_addr < 12'hf00;
   assign ctl = rf_addr >= 12'hf00;
   assign acc = rf_rd || rf_wr;
   assign ram_ok = ram_rd == rf_rd && ram_wr == rf_wr && !periph_rd && !periph_wr;
   assign ctl_ok = periph_rd == rf_rd && periph_wr == rf_wr && !ram_rd && !ram_wr;
   assign quiet = !(ram_rd || ram_wr || periph_rd || periph_wr);
   assign pm_out = {1'b0, pm_addr} >= FLASH_SIZE;
   sequence gap_read_s; rf_rd && gap; endsequence
   sequence pm_absent_s; pm_rd && pm_out; endsequence
   chk_rf_answer: assert property (rf_rd |=> rf_rvalid)
      else $error("no read answer");
   chk_ram_steer: assert property (acc && !gap && !ctl |-> ram_ok)
      else $error("ram steering wrong");
   chk_ctrl_steer: assert property (acc && ctl |-> ctl_ok)
      else $error("control steering wrong");
   chk_gap_quiet: assert property (acc && gap |-> quiet)
      else $error("gap access forwarded");
   chk_gap_read: assert property (gap_read_s |=> rf_rdata == `UNDEF_READ)
      else $error("gap read value wrong");
   chk_resv_read: assert property (rf_rd && ctl && !periph_hit |=> rf_rdata == `UNDEF_READ)
      else $error("reserved read value wrong");
   chk_pm_blank: assert property (pm_absent_s |=> pm_rvalid && pm_rdata == `PM_BLANK)
      else $error("absent flash read wrong");
   chk_pm_drop: assert property (pm_wr && pm_out |-> !flash_wr)
      else $error("absent flash written");
   chk_wd_vector: assert property (pm_addr == `PM_WATCHDOG_VEC |=> pm_region == 3'h3)
      else $error("watchdog region wrong");
   chk_dm_silent: assert property (dm_ack == 1'b0)
      else $error("data memory answered");
endmodule // asd_checker
bind address_space_decoder asd_checker #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) chk_inst (
   .clk, .reset, .rf_rd, .rf_wr, .rf_rvalid, .ram_rd, .ram_wr, .periph_rd, .periph_wr,
   .periph_hit, .pm_rd, .pm_wr, .pm_rvalid, .flash_rd, .flash_wr, .dm_ack, .rf_addr,
   .pm_addr, .rf_rdata, .pm_rdata, .pm_region);
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the address space decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, reset = 1, rf_rd = 0, rf_wr = 0, pm_rd = 0, pm_wr = 0, dm_rd = 0, dm_wr = 0;
   logic [11:0] rf_addr = 12'h000, ram_addr;
   logic [15:0] pm_addr = 16'h0000, dm_addr = 16'h0000, flash_addr;
   logic [7:0] rf_wdata = 8'h00, pm_wdata = 8'h00, rf_rdata, ram_wdata, ram_rdata, periph_addr;
   logic [7:0] periph_wdata, periph_rdata, pm_rdata, flash_wdata, flash_rdata;
   logic [2:0] pm_region;
   logic rf_rvalid, ram_rd, ram_wr, periph_rd, periph_wr, periph_hit, pm_rvalid;
   logic flash_rd, flash_wr, dm_ack;
   int bad_count = 0, tests_run = 0;
   always #25 clk = ~clk;
   // smallest variant so the gap and the absent flash are both reachable
   address_space_decoder #(.RAM_SIZE(13'h0800), .FLASH_SIZE(17'h04000)) address_space_decoder_inst (
      .clk, .reset, .rf_rd, .rf_wr, .rf_addr, .rf_wdata, .rf_rdata, .rf_rvalid, .ram_rd, .ram_wr,
      .ram_addr, .ram_wdata, .ram_rdata, .periph_rd, .periph_wr, .periph_addr, .periph_wdata,
      .periph_rdata, .periph_hit, .pm_rd, .pm_wr, .pm_addr, .pm_wdata, .pm_rdata, .pm_rvalid,
      .pm_region, .flash_rd, .flash_wr, .flash_addr, .flash_wdata, .flash_rdata, .dm_rd, .dm_wr,
      .dm_addr, .dm_ack);
   asd_far_side asd_far_side_inst (.clk, .reset, .ram_rd, .periph_rd, .flash_rd, .ram_addr,
      .periph_addr, .flash_addr, .ram_rdata, .periph_rdata, .flash_rdata, .periph_hit);
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rf_read(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk) #5 rf_rd = 1;
      rf_addr = a;
      @(posedge clk) #5 rf_rd = 0;
      cmp({7'h0, rf_rvalid}, 8'h01);
      cmp(rf_rdata, exp);
   endtask
   task automatic rf_write(input logic [11:0] a, input logic [1:0] exp);
      @(posedge clk) #5 rf_wr = 1;
      rf_addr = a;
      rf_wdata = a[7:0] ^ 8'h3c;
      #1 cmp({6'h0, ram_wr, periph_wr}, {6'h0, exp});
      cmp(ram_wdata, a[7:0] ^ 8'h3c);
      cmp(periph_wdata, a[7:0] ^ 8'h3c);
      cmp(periph_addr, a[7:0]);
      cmp({4'h0, ram_addr[11:8]}, {4'h0, a[11:8]});
      @(posedge clk) #5 rf_wr = 0;
   endtask
   task automatic t_reg_file;
      rf_read(12'h000, 8'h5a);
      rf_read(12'h7ff, 8'ha5);
      rf_read(12'h800, 8'h00);
      rf_read(12'heff, 8'h00);
      rf_read(12'hf00, 8'ha5);
      rf_read(12'hfff, 8'h00);
      rf_write(12'h7ff, 2'h2);
      rf_write(12'h800, 2'h0);
      rf_write(12'hf10, 2'h1);
      $display("test reg_file done");
   endtask
   task automatic t_prog;
      logic [15:0] pa [10] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h0037,
         16'h0038, 16'h3fff, 16'h4000, 16'hffff};
      logic [2:0] pr [10] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h6, 3'h7, 3'h7, 3'h5, 3'h5};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk) #5 pm_rd = 1;
         pm_addr = pa[i];
         @(posedge clk) #5 pm_rd = 0;
         cmp({7'h0, pm_rvalid}, 8'h01);
         cmp({5'h0, pm_region}, {5'h0, pr[i]});
         cmp(pm_rdata, pa[i] < 16'h4000 ? pa[i][7:0] ^ pa[i][15:8] : 8'hff);
      end
      @(posedge clk) #5 pm_wr = 1;
      pm_addr = 16'h8000;
      pm_wdata = 8'h96;
      #1 cmp({7'h0, flash_wr}, 8'h00);
      @(posedge clk) #5 pm_addr = 16'h0038;
      #1 cmp({7'h0, flash_wr}, 8'h01);
      cmp(flash_wdata, 8'h96);
      cmp(flash_addr[7:0], 8'h38);
      @(posedge clk) #5 pm_wr = 0;
      $display("test prog done");
   endtask
   task automatic t_data;
      @(posedge clk) #5 dm_rd = 1;
      dm_wr = 1;
      dm_addr = 16'h1234;
      @(posedge clk) #5 cmp({7'h0, dm_ack}, 8'h00);
      dm_rd = 0;
      dm_wr = 0;
      $display("test data done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #5 reset = 0;
      t_reg_file;
      t_prog;
      t_data;
      test_done;
   end
   initial begin
      #(400 * 50);
      bad_count++;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
